// ===== design/cgsf_map.svh
// Address map, field positions, reset values and timing counts of the
// clock generator status and loop filter register block.
// Assumes a 32-bit classic Wishbone slave with one register per word.
`ifndef CGSF_MAP_SVH
`define CGSF_MAP_SVH

// Word indices, taken from address bits 3:2
`define CGSF_IDX_STAT_ONE     2'h0
`define CGSF_IDX_STAT_TWO     2'h1
`define CGSF_IDX_FILT_UPPER   2'h2
`define CGSF_IDX_FILT_LOWER   2'h3

// Status one field positions
`define CGSF_S1_MODE_HI       7
`define CGSF_S1_MODE_LO       6
`define CGSF_S1_REF_KIND      5
`define CGSF_S1_LOCK_LOST     4
`define CGSF_S1_LOCKED        3
`define CGSF_S1_CLOCK_LOST    2
`define CGSF_S1_EXT_VALID     1
`define CGSF_S1_IRQ_FLAG      0

// Clock mode status codes
`define CGSF_MST_SELF         2'h0
`define CGSF_MST_FLL_INT      2'h1
`define CGSF_MST_BYP_EXT      2'h2
`define CGSF_MST_FLL_EXT      2'h3

// Clock select codes
`define CGSF_SEL_SELF         2'h0
`define CGSF_SEL_FLL_INT      2'h1
`define CGSF_SEL_BYP_EXT      2'h2
`define CGSF_SEL_FLL_EXT      2'h3

// Filter layout and reset value
`define CGSF_FILT_UPPER_W     4
`define CGSF_FILT_RESET       12'h000
`define CGSF_HOLD_RESET       8'h00
`define CGSF_RD_ZERO          32'h0000_0000
`define CGSF_PAD24            24'h00_0000
`define CGSF_PAD7             7'h00

// Cycles that a filter latch sequence stays busy after an upper write
`define CGSF_LATCH_CYCLES     3'h4
`define CGSF_LATCH_ZERO       3'h0
`define CGSF_LATCH_ONE        3'h1

`endif

// ===== design/cgsf_pkg.sv
// Types shared by the clock generator status and filter register block.
// Assumes cgsf_map.svh holds all numeric constants except the mode encodings below.
package cgsf_pkg;

  // Clock generator modes, Gray coded along off, self, engaged, bypass
  typedef enum logic [2:0] {
    CGSF_OFF      = 3'h0,
    CGSF_SELF     = 3'h1,
    CGSF_FLL_INT  = 3'h3,
    CGSF_FLL_EXT  = 3'h2,
    CGSF_BYP_EXT  = 3'h6
  } cgsf_mode_e;

  typedef logic [11:0] cgsf_filter_t;

endpackage : cgsf_pkg

// ===== design/cgsf_sync.sv
// Two-flop synchroniser for a bus of levels.
// Assumes the input levels come from another clock domain.
`timescale 1ns/1ps
`default_nettype none

module cgsf_sync #(
  parameter int W = 2
) (
  input  wire logic         i_mclk,   // Block clock
  input  wire logic         i_reset,  // Synchronous reset, active high
  input  wire logic [W-1:0] i_async,  // Level from the other domain
  output logic      [W-1:0] o_sync    // Level in the block domain
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : cgsf_sync

`default_nettype wire

// ===== design/cgsf_regs.sv
// Status and loop filter registers of the internal clock generator,
// with the small mode tracker that drives the clock mode status.
// Assumes a classic Wishbone master, and event and level inputs from the
// loop, lock detector and loss detectors on the same clock.
//
// Function
// RULE1 - Status one bits 7:6 report mode: 00 self, 01 int, 10 bypass, 11 ext.
// RULE2 - Mode status follows clock select only after select is synchronised.
// RULE3 - Status one bit 5 is 0 for external clock, 1 for crystal.
// RULE4 - Bit 4 sticky lock lost flag; held until cleared; enable picks action.
// RULE5 - Bit 3 shows current lock; forced 0 in off, self and bypass modes.
// RULE6 - Bit 2 sticky clock lost flag; held until cleared; enable picks action.
// RULE7 - Bit 1 shows external reference stable and fast enough.
// RULE8 - Bit 0 is set while a clock generator interrupt is pending.
// RULE9 - Flag clears on reset, or on status read with flag set then write 1.
// RULE10 - A new interrupt during the clearing sequence restarts it; flag stays set.
// RULE11 - Writing 0 to the flag bit leaves it unchanged.
// RULE12 - Status two bit 0 sets after two good error samples, clock not static.
// RULE13 - Leaving off with select X1 waits for oscillator stable before switching.
// RULE14 - In self mode oscillator monitoring starts only once stable is set.
// RULE15 - Oscillator stable clears whenever the generator enters off.
// RULE16 - 12-bit filter value: upper 4 bits in upper register, lower 8 in lower.
// RULE17 - Filter is read only unless clock select is 00.
// RULE18 - In self mode an upper write loads all 12 filter bits at once.
// RULE19 - Upper write ignored while the previous latch sequence is unfinished.
// RULE20 - Lock lost gives interrupt if its reset enable is 0, else reset.
// RULE21 - Clock lost gives interrupt if its reset enable is 0, else reset.
// RULE22 - Software writes lower filter register first, then upper.
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cgsf_map.svh"

module cgsf_regs (
  input  wire logic        i_mclk,                   // 40 MHz clock
  input  wire logic        i_reset,                  // Synchronous reset, active high
  // Wishbone slave
  input  wire logic        i_wb_cyc,                 // Cycle
  input  wire logic        i_wb_stb,                 // Strobe
  input  wire logic        i_wb_we,                  // Write enable
  input  wire logic [3:0]  i_wb_adr,                 // Byte address
  input  wire logic [3:0]  i_wb_sel,                 // Byte enables
  input  wire logic [31:0] i_wb_dat,                 // Write data
  output logic      [31:0] o_wb_dat,                 // Read data
  output logic             o_wb_ack,                 // Acknowledge
  // Control from the clock generator control registers
  input  wire logic [1:0]  i_clock_select,           // Requested mode, other domain
  input  wire logic        i_lock_lost_reset_enable, // 1: reset on lock loss
  input  wire logic        i_clock_lost_reset_enable,// 1: reset on clock loss
  input  wire logic        i_stop_request,           // Generator goes to off
  // Status from the loop and detectors
  input  wire logic        i_reference_kind,         // 1: crystal, 0: external clock
  input  wire logic        i_fll_locked,             // Lock detector level
  input  wire logic        i_lock_lost_event,        // Pulse: unexpected lock loss
  input  wire logic        i_clock_lost_event,       // Pulse: loss of clock
  input  wire logic        i_ext_ref_valid,          // External reference usable
  input  wire logic        i_osc_sample,             // Pulse: new count error sample
  input  wire logic        i_osc_err_small,          // Error change within unlock limit
  input  wire logic        i_osc_clock_active,       // Oscillator clock not static
  input  wire logic        i_loop_load,              // Pulse: loop updates filter
  input  wire logic [11:0] i_loop_value,             // Filter value from the loop
  // Results
  output logic      [11:0] o_filter_value,           // Active oscillator filter value
  output logic      [1:0]  o_clock_mode_status,      // Current mode code
  output logic             o_osc_monitor_en,         // Monitor oscillator clock
  output logic             o_irq_request,            // Interrupt request level
  output logic             o_reset_request           // Reset request level
);

  ////////////////////////////////////////////////////////////////////////////
  // Clock select crossing

  logic [1:0] clock_select;

  cgsf_sync #(.W(2)) u_sel_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_async (i_clock_select),
    .o_sync  (clock_select)
  );  // see RULE2

  ////////////////////////////////////////////////////////////////////////////
  // Mode tracker

  cgsf_pkg::cgsf_mode_e mode_q;
  cgsf_pkg::cgsf_mode_e mode_d;
  cgsf_pkg::cgsf_mode_e target;
  logic                 osc_stable_q;

  // Modes needing the oscillator fall back to self mode until it is stable
  assign target = (clock_select == `CGSF_SEL_SELF)    ? cgsf_pkg::CGSF_SELF :
                  (clock_select == `CGSF_SEL_FLL_INT) ?
                    (osc_stable_q ? cgsf_pkg::CGSF_FLL_INT : cgsf_pkg::CGSF_SELF) :
                  (clock_select == `CGSF_SEL_BYP_EXT) ?
                    (i_ext_ref_valid ? cgsf_pkg::CGSF_BYP_EXT : cgsf_pkg::CGSF_SELF) :
                    ((i_ext_ref_valid && osc_stable_q) ? cgsf_pkg::CGSF_FLL_EXT
                                                       : cgsf_pkg::CGSF_SELF);  // see RULE13

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      cgsf_pkg::CGSF_OFF: begin
        if (!i_stop_request) begin
          if (clock_select == `CGSF_SEL_BYP_EXT && i_ext_ref_valid) begin
            mode_d = cgsf_pkg::CGSF_BYP_EXT;
          end else begin
            mode_d = cgsf_pkg::CGSF_SELF;  // see RULE13
          end
        end
      end
      default: begin
        if (i_stop_request) begin
          mode_d = cgsf_pkg::CGSF_OFF;
        end else begin
          mode_d = target;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      mode_q <= cgsf_pkg::CGSF_SELF;
    end else begin
      mode_q <= mode_d;
    end
  end

  wire in_self   = (mode_q == cgsf_pkg::CGSF_SELF);
  wire fll_on    = (mode_q == cgsf_pkg::CGSF_FLL_INT) || (mode_q == cgsf_pkg::CGSF_FLL_EXT);

  assign o_clock_mode_status = (mode_q == cgsf_pkg::CGSF_FLL_INT) ? `CGSF_MST_FLL_INT :
                               (mode_q == cgsf_pkg::CGSF_BYP_EXT) ? `CGSF_MST_BYP_EXT :
                               (mode_q == cgsf_pkg::CGSF_FLL_EXT) ? `CGSF_MST_FLL_EXT :
                                                                    `CGSF_MST_SELF;  // see RULE1

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator stable detection

  logic prev_ok_q;
  wire  sample_ok = i_osc_err_small && i_osc_clock_active;

  always_ff @(posedge i_mclk) begin
    if (i_reset || mode_d == cgsf_pkg::CGSF_OFF) begin
      osc_stable_q <= 1'b0;  // see RULE15
      prev_ok_q    <= 1'b0;
    end else if (!i_osc_clock_active) begin
      osc_stable_q <= 1'b0;
      prev_ok_q    <= 1'b0;
    end else if (i_osc_sample) begin
      osc_stable_q <= sample_ok && prev_ok_q;  // see RULE12
      prev_ok_q    <= sample_ok;
    end
  end

  assign o_osc_monitor_en = in_self && osc_stable_q;  // see RULE14

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        ack_q;
  logic [31:0] rd_q;
  wire         access  = i_wb_cyc && i_wb_stb && !ack_q;
  wire  [1:0]  idx     = i_wb_adr[3:2];
  wire         wr_lane = access && i_wb_we && i_wb_sel[0];
  wire         rd_acc  = access && !i_wb_we;
  wire         hit_s1  = (idx == `CGSF_IDX_STAT_ONE);
  wire         hit_fu  = (idx == `CGSF_IDX_FILT_UPPER);
  wire         hit_fl  = (idx == `CGSF_IDX_FILT_LOWER);
  wire         wr_s1   = wr_lane && hit_s1;
  wire         wr_fu   = wr_lane && hit_fu;
  wire         wr_fl   = wr_lane && hit_fl;
  wire         rd_s1   = rd_acc && hit_s1;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags, interrupt flag and clearing sequence

  logic lock_lost_q;
  logic clock_lost_q;
  logic irq_flag_q;
  logic clr_armed_q;

  wire irq_event  = (i_lock_lost_event && !i_lock_lost_reset_enable) ||
                    (i_clock_lost_event && !i_clock_lost_reset_enable);  // see RULE20 RULE21
  wire clr_finish = wr_s1 && i_wb_dat[`CGSF_S1_IRQ_FLAG] && clr_armed_q;  // see RULE11

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      irq_flag_q  <= 1'b0;  // see RULE9
      clr_armed_q <= 1'b0;
    end else if (irq_event) begin
      irq_flag_q  <= 1'b1;  // see RULE8
      clr_armed_q <= 1'b0;  // see RULE10
    end else if (clr_finish) begin
      irq_flag_q  <= 1'b0;  // see RULE9
      clr_armed_q <= 1'b0;
    end else if (rd_s1 && irq_flag_q) begin
      clr_armed_q <= 1'b1;
    end
  end

  // Sticky flags clear with the completed flag clearing sequence
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      lock_lost_q  <= 1'b0;
      clock_lost_q <= 1'b0;
    end else begin
      lock_lost_q  <= i_lock_lost_event || (lock_lost_q && !clr_finish);    // see RULE4
      clock_lost_q <= i_clock_lost_event || (clock_lost_q && !clr_finish);  // see RULE6
    end
  end

  assign o_irq_request   = irq_flag_q;
  assign o_reset_request = (lock_lost_q && i_lock_lost_reset_enable) ||
                           (clock_lost_q && i_clock_lost_reset_enable);  // see RULE20 RULE21

  ////////////////////////////////////////////////////////////////////////////
  // Loop filter value

  cgsf_pkg::cgsf_filter_t filter_q;
  logic [7:0]             lower_hold_q;
  logic [2:0]             latch_cnt_q;

  wire sw_may_write = in_self && (clock_select == `CGSF_SEL_SELF);  // see RULE17
  wire latch_busy   = (latch_cnt_q != `CGSF_LATCH_ZERO);
  wire upper_take   = wr_fu && sw_may_write && !latch_busy;  // see RULE19

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      lower_hold_q <= `CGSF_HOLD_RESET;
    end else if (wr_fl && sw_may_write) begin
      lower_hold_q <= i_wb_dat[7:0];  // see RULE22
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      filter_q    <= `CGSF_FILT_RESET;
      latch_cnt_q <= `CGSF_LATCH_ZERO;
    end else if (upper_take) begin
      filter_q    <= {i_wb_dat[`CGSF_FILT_UPPER_W-1:0], lower_hold_q};  // see RULE18
      latch_cnt_q <= `CGSF_LATCH_CYCLES;
    end else begin
      if (i_loop_load && fll_on) begin
        filter_q <= i_loop_value;
      end
      if (latch_busy) begin
        latch_cnt_q <= latch_cnt_q - `CGSF_LATCH_ONE;
      end
    end
  end

  assign o_filter_value = filter_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge

  wire [7:0] stat_one = {o_clock_mode_status,            // see RULE1
                         i_reference_kind,               // see RULE3
                         lock_lost_q,
                         i_fll_locked && fll_on,         // see RULE5
                         clock_lost_q,
                         i_ext_ref_valid,                // see RULE7
                         irq_flag_q};
  wire [7:0] stat_two = {`CGSF_PAD7, osc_stable_q};

  wire [7:0] rd_byte = hit_s1 ? stat_one :
                       (idx == `CGSF_IDX_STAT_TWO) ? stat_two :
                       hit_fu ? {4'h0, filter_q[11:8]} :
                       filter_q[7:0];  // see RULE16

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ack_q <= 1'b0;
      rd_q  <= `CGSF_RD_ZERO;
    end else begin
      ack_q <= access;
      if (rd_acc) begin
        rd_q <= {`CGSF_PAD24, rd_byte};
      end
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_sel_sync_lag: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE2
    ##2 (clock_select == $past(i_clock_select, 2)))
    else $error("clock select not two cycles behind");

  a_mode_code_map: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE1
    (mode_q == cgsf_pkg::CGSF_FLL_EXT) |-> (stat_one[`CGSF_S1_MODE_HI:`CGSF_S1_MODE_LO] == `CGSF_MST_FLL_EXT))
    else $error("engaged external mode code wrong");

  a_lock_forced_low: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE5
    !fll_on |-> !stat_one[`CGSF_S1_LOCKED])
    else $error("lock bit set outside engaged modes");

  a_lock_lost_holds: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE4
    (i_lock_lost_event ##1 !clr_finish[*2]) |-> lock_lost_q)
    else $error("lock lost flag dropped early");

  a_clk_lost_holds: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE6
    (i_clock_lost_event ##1 !clr_finish[*2]) |-> clock_lost_q)
    else $error("clock lost flag not set");

  a_irq_on_event: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE8
    irq_event |=> (irq_flag_q && !clr_armed_q))
    else $error("interrupt flag not raised");

  a_irq_read_clear: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE9
    (rd_s1 && irq_flag_q && !irq_event) ##1 (!irq_event)[*2] ##1
      (wr_s1 && i_wb_dat[`CGSF_S1_IRQ_FLAG] && !irq_event) |=> !irq_flag_q)
    else $error("clearing sequence did not clear flag");

  a_irq_restart: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE10
    (clr_armed_q && irq_event) |=> (irq_flag_q && !clr_armed_q))
    else $error("new interrupt lost during clearing");

  a_irq_write_zero: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE11
    (irq_flag_q && wr_s1 && !i_wb_dat[0]) |=> irq_flag_q)
    else $error("writing zero changed the flag");

  a_stable_off_clr: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE15
    (mode_q == cgsf_pkg::CGSF_OFF) |-> !osc_stable_q)
    else $error("oscillator stable set in off");

  a_stable_two_smp: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE12
    $rose(osc_stable_q) |-> $past(i_osc_sample) && $past(prev_ok_q))
    else $error("stable set without two good samples");

  a_off_exit_wait: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE13
    ($past(mode_q) == cgsf_pkg::CGSF_OFF) && clock_select[0] |-> !fll_on)
    else $error("engaged mode entered straight from off");

  a_monitor_gate: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE14
    o_osc_monitor_en |-> stat_two[0] && (o_clock_mode_status == `CGSF_MST_SELF) && (mode_q != cgsf_pkg::CGSF_OFF))
    else $error("monitor enabled without stable oscillator");

  a_filter_ro: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE17
    (wr_fu && !sw_may_write && !(i_loop_load && fll_on)) |=> $stable(filter_q))
    else $error("filter changed outside self mode");

  a_filter_load: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE18
    upper_take |=> (filter_q == {$past(i_wb_dat[3:0]), $past(lower_hold_q)}) ##1 latch_busy[*3])
    else $error("upper write did not load all filter bits");

  a_latch_block: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE19
    (wr_fu && latch_busy && !(i_loop_load && fll_on)) |=> $stable(filter_q))
    else $error("filter changed during latch sequence");

  a_reset_req: assert property (@(posedge i_mclk) disable iff (i_reset) // see RULE21
    (i_clock_lost_event && i_clock_lost_reset_enable) ##1 i_clock_lost_reset_enable
      |-> o_reset_request)
    else $error("clock loss gave no reset request");

endmodule : cgsf_regs

`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the clock generator status and filter registers.
// Assumes cgsf_regs as the device under test, driven over classic Wishbone.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        i_mclk;
  logic        i_reset;
  logic        cyc, stb, we, ack;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, rd;
  logic [1:0]  csel, mode;
  logic        lock_lost_reset_enable, clock_lost_reset_enable, stop, refk, locked, lolev, locev, extv, osmp, oerr, oact, lload;
  logic [11:0] lval, filt;
  logic        mon, irq, rst;
  int          bad_count, num_checks;

  cgsf_regs i_cgsf_regs (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_clock_select(csel), .i_lock_lost_reset_enable(lock_lost_reset_enable), .i_clock_lost_reset_enable(clock_lost_reset_enable),
    .i_stop_request(stop), .i_reference_kind(refk), .i_fll_locked(locked),
    .i_lock_lost_event(lolev), .i_clock_lost_event(locev), .i_ext_ref_valid(extv),
    .i_osc_sample(osmp), .i_osc_err_small(oerr), .i_osc_clock_active(oact),
    .i_loop_load(lload), .i_loop_value(lval), .o_filter_value(filt),
    .o_clock_mode_status(mode), .o_osc_monitor_en(mon), .o_irq_request(irq), .o_reset_request(rst)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : tick

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task pchk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t port got %h exp %h", $time, got, exp);
    end
  endtask : pchk

  // One classic cycle; request held until ack is sampled high
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    if (n >= 20) begin
      bad_count++;
      $display("[ERR] %0t no acknowledge", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge i_mclk);
  endtask : bus

  task rchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    cmp(rd, {24'h00_0000, e});
  endtask : rchk

  task good_smp;
    osmp <= 1'b1;
    tick(1);
    osmp <= 1'b0;
    tick(1);
  endtask : good_smp

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    rchk(4'h0, 8'h00);
    rchk(4'h4, 8'h00);
    rchk(4'h8, 8'h00);
    pchk(12'(irq), 12'h000);
    $display("test reset done");
  endtask : t_reset

  task t_status;
    refk   <= 1'b1;
    extv   <= 1'b1;
    locked <= 1'b1;
    tick(2);
    rchk(4'h0, 8'h22);
    refk <= 1'b0;
    extv <= 1'b0;
    tick(2);
    rchk(4'h0, 8'h00);
    $display("test status done");
  endtask : t_status

  task t_filter;
    bus(1'b1, 4'hC, 8'hA5);
    pchk(filt, 12'h000);
    bus(1'b1, 4'h8, 8'h13);
    bus(1'b1, 4'h8, 8'h0F);
    pchk(filt, 12'h3A5);
    rchk(4'h8, 8'h03);
    rchk(4'hC, 8'hA5);
    tick(6);
    bus(1'b1, 4'hC, 8'h11);
    bus(1'b1, 4'h8, 8'h07);
    pchk(filt, 12'h711);
    csel <= 2'h1;
    tick(6);
    bus(1'b1, 4'hC, 8'h22);
    bus(1'b1, 4'h8, 8'h05);
    pchk(filt, 12'h711);
    csel <= 2'h0;
    tick(6);
    $display("test filter done");
  endtask : t_filter

  task t_irq;
    lolev <= 1'b1;
    tick(1);
    lolev <= 1'b0;
    tick(1);
    pchk(12'(irq), 12'h001);
    pchk(12'(rst), 12'h000);
    bus(1'b1, 4'h0, 8'h01);
    rchk(4'h0, 8'h11);
    bus(1'b1, 4'h0, 8'h00);
    rchk(4'h0, 8'h11);
    lolev <= 1'b1;
    tick(1);
    lolev <= 1'b0;
    bus(1'b1, 4'h0, 8'h01);
    rchk(4'h0, 8'h11);
    bus(1'b1, 4'h0, 8'h01);
    rchk(4'h0, 8'h00);
    pchk(12'(irq), 12'h000);
    $display("test interrupt done");
  endtask : t_irq

  task t_mode;
    good_smp();
    good_smp();
    rchk(4'h4, 8'h01);
    pchk(12'(mon), 12'h001);
    csel <= 2'h1;
    tick(2);
    pchk(12'(mode), 12'h000);
    tick(4);
    rchk(4'h0, 8'h48);
    pchk(12'(mon), 12'h000);
    lval  <= 12'h5C3;
    lload <= 1'b1;
    tick(1);
    lload <= 1'b0;
    tick(1);
    pchk(filt, 12'h5C3);
    stop <= 1'b1;
    tick(3);
    pchk(12'(mode), 12'h000);
    rchk(4'h4, 8'h00);
    stop <= 1'b0;
    tick(6);
    pchk(12'(mode), 12'h000);
    good_smp();
    good_smp();
    tick(2);
    pchk(12'(mode), 12'h001);
    extv <= 1'b1;
    csel <= 2'h3;
    tick(6);
    rchk(4'h0, 8'hCA);
    csel <= 2'h2;
    tick(6);
    rchk(4'h0, 8'h82);
    stop <= 1'b1;
    tick(3);
    stop <= 1'b0;
    tick(2);
    rchk(4'h0, 8'h82);
    csel <= 2'h0;
    tick(6);
    pchk(12'(mode), 12'h000);
    $display("test mode done");
  endtask : t_mode

  task t_clklost;
    clock_lost_reset_enable <= 1'b1;
    locev <= 1'b1;
    tick(1);
    locev <= 1'b0;
    tick(1);
    rchk(4'h0, 8'h06);
    pchk(12'(rst), 12'h001);
    pchk(12'(irq), 12'h000);
    $display("test clock loss done");
  endtask : t_clklost

  task t_rerst;
    lolev <= 1'b1;
    tick(1);
    lolev <= 1'b0;
    tick(1);
    pchk(12'(irq), 12'h001);
    i_reset <= 1'b1;
    tick(2);
    i_reset <= 1'b0;
    tick(1);
    pchk(12'(irq), 12'h000);
    pchk(12'(rst), 12'h000);
    pchk(filt, 12'h000);
    rchk(4'h0, 8'h02);
    lock_lost_reset_enable <= 1'b1;
    lolev <= 1'b1;
    tick(1);
    lolev <= 1'b0;
    tick(1);
    pchk(12'(rst), 12'h001);
    pchk(12'(irq), 12'h000);
    $display("test mid reset done");
  endtask : t_rerst

  //////////////////////////////////////////////////////////////////////////////
  // Clock, reset, sequence and watchdog
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  initial begin
    {cyc, stb, we, lock_lost_reset_enable, clock_lost_reset_enable, stop, refk, locked, lolev, locev, extv, osmp, lload} = '0;
    oerr = 1'b1;
    oact = 1'b1;
    adr  = 4'h0;
    sel  = 4'h1;
    wdat = 32'h0000_0000;
    csel = 2'h0;
    lval = 12'h000;
    bad_count  = 0;
    num_checks = 0;
    i_reset = 1'b1;
    tick(16);
    i_reset <= 1'b0;
    tick(1);
    t_reset();
    t_status();
    t_filter();
    t_irq();
    t_mode();
    t_clklost();
    t_rerst();
    close_out();
  end

  initial begin
    tick(5000);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
endmodule : tb_top

`default_nettype wire
